//--- rtl/cbx_exec.sv
// Decode and execute for flag branches and file bit clear.
// Assumes instruction words arrive one per cycle, latched at phase Q1.
//
// What this block does
// - Signed 8-bit offset, doubled to bytes
// - Taken target is PC plus 2 plus offset
// - All handled opcodes are single word
// - Not taken one cycle, taken two
// - Q4 writes PC only when taken
// - 1001 bbba ffff ffff clears bit, flags kept
// - Override bit zero selects access bank
// - Override bit one uses bank select
// - 1110 0110 branches when negative set
// - 1110 0011 branches when carry clear
// - 1110 0111 branches when negative clear
// - 1110 0010 branches when carry set
`timescale 1ns/1ps
module cbx_exec (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic [15:0] instr_in,
  input wire logic [cbx_pkg::PC_W-1:0] instr_addr_in,
  input wire logic carry_in,
  input wire logic negative_in,
  input wire logic [3:0] bank_select_reg_in,
  input wire logic [7:0] file_rdata_in,
  output logic [1:0] phase_out,
  output logic pc_load_out,
  output logic [cbx_pkg::PC_W-1:0] pc_value_out,
  output logic flush_out,
  output logic file_we_out,
  output logic [cbx_pkg::DADDR_W-1:0] file_addr_out,
  output logic [7:0] file_wdata_out,
  output logic busy_out
);
  import cbx_pkg::*;

  // ****************************************
  // Phase and decode
  // ****************************************
  typedef enum logic [1:0] {EXEC, NOP_CYCLE} cyc_e;
  cyc_e cyc_reg;
  logic [1:0] phase;
  logic [15:0] ir_reg;
  logic [PC_W-1:0] ia_reg;
  logic c_reg;
  logic n_reg;
  logic is_bc, is_bnc, is_bn, is_bnn, is_branch, is_bclr, cond;
  logic [PC_W-1:0] target;
  logic [DADDR_W-1:0] faddr;
  logic [2:0] bitn;

  cbx_phase_gen u_phase (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .phase_out(phase)
  );

  cbx_target_calc #(.PCW(PC_W)) u_target (
    .pc_in(ia_reg),
    .disp_in(ir_reg[7:0]),
    .target_out(target)
  );

  // Latch word and flags at Q1 of every executing cycle
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      ir_reg <= 16'h0000;
      ia_reg <= PC_RESET;
      c_reg <= 1'b0;
      n_reg <= 1'b0;
    end else if (phase == PHASE_RESET && cyc_reg == EXEC) begin
      ir_reg <= instr_in;
      ia_reg <= instr_addr_in;
      c_reg <= carry_in;
      n_reg <= negative_in;
    end
  end

  // Opcode match, each in one word
  assign is_bc = (ir_reg[15:8] == OPC_BR_CARRY_SET);
  assign is_bnc = (ir_reg[15:8] == OPC_BR_CARRY_CLR);
  assign is_bn = (ir_reg[15:8] == OPC_BR_NEG_SET);
  assign is_bnn = (ir_reg[15:8] == OPC_BR_NEG_CLR);
  assign is_branch = is_bc | is_bnc | is_bn | is_bnn;
  assign is_bclr = (ir_reg[15:12] == OPC_BIT_CLEAR);
  // Condition from flags held since cycle start
  assign cond = (is_bc & c_reg) | (is_bnc & ~c_reg) | (is_bn & n_reg) | (is_bnn & ~n_reg);
  assign bitn = ir_reg[BIT_POS_LSB+2:BIT_POS_LSB];

  // Bank choice: access bank splits low and high halves
  always_comb begin
    if (ir_reg[BANK_OVR_POS]) begin
      faddr = {bank_select_reg_in, ir_reg[7:0]};
    end else if (ir_reg[7:0] < ACCESS_SPLIT) begin
      faddr = {ACCESS_BANK_LO, ir_reg[7:0]};
    end else begin
      faddr = {ACCESS_BANK_HI, ir_reg[7:0]};
    end
  end

  // ****************************************
  // Cycle sequencing
  // ****************************************
  // Taken branch adds one dead cycle
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      cyc_reg <= EXEC;
    end else if (phase == PHASE_Q4) begin
      unique case (cyc_reg)
        EXEC: begin
          cyc_reg <= (is_branch && cond) ? NOP_CYCLE : EXEC;
        end
        NOP_CYCLE: begin
          cyc_reg <= EXEC;
        end
        default: begin
          cyc_reg <= EXEC;
        end
      endcase
    end
  end

  // PC write only at Q4 of a taken first cycle
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      pc_load_out <= 1'b0;
      pc_value_out <= PC_RESET;
      flush_out <= 1'b0;
    end else begin
      pc_load_out <= (phase == 2'h2) && cyc_reg == EXEC && is_branch && cond;
      flush_out <= (phase == 2'h2) && cyc_reg == EXEC && is_branch && cond;
      if ((phase == 2'h2) && cyc_reg == EXEC && is_branch && cond) begin
        pc_value_out <= target;
      end
    end
  end

  // Bit clear: address in Q2, write at Q4; flags never touched
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      file_we_out <= 1'b0;
      file_addr_out <= '0;
      file_wdata_out <= 8'h00;
    end else begin
      file_addr_out <= faddr;
      file_we_out <= (phase == 2'h2) && cyc_reg == EXEC && is_bclr;
      file_wdata_out <= file_rdata_in & ~(8'h01 << bitn);
    end
  end

  // Phase and busy registered outputs
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      phase_out <= PHASE_RESET;
      busy_out <= 1'b0;
    end else begin
      phase_out <= phase;
      busy_out <= (cyc_reg == NOP_CYCLE);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  // Q3 of an executing cycle is where every outcome is decided
  sequence s_q3_exec;
    phase == 2'h2 && cyc_reg == EXEC;
  endsequence

  // Q3 of a branch whose condition holds
  sequence s_q3_taken;
    phase == 2'h2 && cyc_reg == EXEC && is_branch && cond;
  endsequence

  // Q3 of any word that must leave the program counter alone
  sequence s_q3_untaken;
    phase == 2'h2 && cyc_reg == EXEC && !(is_branch && cond);
  endsequence

  // Q3 of a bit clear word
  sequence s_q3_bclr;
    phase == 2'h2 && cyc_reg == EXEC && is_bclr;
  endsequence

  // Busy trails the cycle state by one clock, so the four dead
  // quarters show two clocks after the load pulse, not one
  sequence s_dead_cycle;
    busy_out[*4];
  endsequence

  // Load and flush together, then the whole dead cycle
  sequence s_load_then_dead;
    (pc_load_out && flush_out) ##2 s_dead_cycle;
  endsequence

  // ****************************************
  // Properties
  // ****************************************
  // A taken branch loads once, then stalls for the dead cycle
  chk_taken_load: assert property (@(posedge mclk_in) disable iff (reset_in)
    s_q3_taken |=> s_load_then_dead)
    else $error("taken branch did not load and stall");

  // A false condition leaves the program counter alone
  chk_nottaken_quiet: assert property (@(posedge mclk_in) disable iff (reset_in)
    s_q3_untaken |=> !pc_load_out)
    else $error("untaken branch wrote pc");

  // An untaken word takes one cycle: no dead cycle follows it
  chk_untaken_short: assert property (@(posedge mclk_in) disable iff (reset_in)
    s_q3_untaken |=> ##1 (!busy_out)[*4])
    else $error("untaken word stalled the sequencer");

  // Both pulses last exactly one clock
  chk_pulse_width: assert property (@(posedge mclk_in) disable iff (reset_in)
    s_q3_exec |=> ##1 (!pc_load_out && !file_we_out))
    else $error("load or write pulse too long");

  // Writes are seen only while the internal quarter is Q4
  chk_q4_only: assert property (@(posedge mclk_in) disable iff (reset_in)
    (pc_load_out || file_we_out) |-> phase == PHASE_Q4)
    else $error("write outside the fourth quarter");

  // The dead cycle neither loads nor writes, and keeps the captured word
  chk_dead_no_write: assert property (@(posedge mclk_in) disable iff (reset_in)
    cyc_reg == NOP_CYCLE |=> !pc_load_out && !file_we_out)
    else $error("dead cycle did work");
  chk_dead_hold: assert property (@(posedge mclk_in) disable iff (reset_in)
    cyc_reg == NOP_CYCLE |=> $stable(ir_reg) && $stable(c_reg) && $stable(n_reg))
    else $error("word or flags reloaded in dead cycle");

  // The stall ends after exactly four clocks
  chk_busy_end: assert property (@(posedge mclk_in) disable iff (reset_in)
    s_dead_cycle |=> !busy_out)
    else $error("busy held too long");

  // Target arithmetic, sign of the offset included
  chk_target_math: assert property (@(posedge mclk_in) disable iff (reset_in)
    pc_load_out |-> pc_value_out == $past(ia_reg) + PC_STEP
      + {{(PC_W-9){$past(ir_reg[7])}}, $past(ir_reg[7:0]), 1'b0})
    else $error("branch target wrong");
  chk_disp_sign: assert property (@(posedge mclk_in) disable iff (reset_in)
    (pc_load_out && $past(ir_reg[7])) |-> pc_value_out <= $past(ia_reg) + PC_STEP)
    else $error("negative offset went forward");

  // The target output only moves together with a load pulse
  chk_target_hold: assert property (@(posedge mclk_in) disable iff (reset_in)
    $changed(pc_value_out) |-> pc_load_out)
    else $error("target changed without a load");

  // One condition check per branch opcode
  chk_bc_cond: assert property (@(posedge mclk_in) disable iff (reset_in)
    (phase == 2'h2 && cyc_reg == EXEC && is_bc && !c_reg) |=> !pc_load_out)
    else $error("carry-set branch taken with carry low");
  chk_bnc_cond: assert property (@(posedge mclk_in) disable iff (reset_in)
    (phase == 2'h2 && cyc_reg == EXEC && is_bnc && !c_reg) |=> pc_load_out)
    else $error("carry-clear branch not taken");
  chk_bn_cond: assert property (@(posedge mclk_in) disable iff (reset_in)
    (phase == 2'h2 && cyc_reg == EXEC && is_bn && n_reg) |=> pc_load_out)
    else $error("negative branch not taken");
  chk_bnn_cond: assert property (@(posedge mclk_in) disable iff (reset_in)
    (phase == 2'h2 && cyc_reg == EXEC && is_bnn && n_reg) |=> !pc_load_out)
    else $error("not-negative branch taken when negative");

  // Flags are captured with the word at the start of the cycle
  chk_flag_capture: assert property (@(posedge mclk_in) disable iff (reset_in)
    (phase == PHASE_RESET && cyc_reg == EXEC) |=> c_reg == $past(carry_in)
      && n_reg == $past(negative_in))
    else $error("flags not captured at cycle start");

  // After a one-cycle word the very next quarter one takes a fresh word,
  // so no handled opcode can swallow a second operand word
  chk_single_word: assert property (@(posedge mclk_in) disable iff (reset_in)
    (phase == PHASE_Q4 && cyc_reg == EXEC && !(is_branch && cond)) |=> ##1
      ir_reg == $past(instr_in))
    else $error("next word not taken after one cycle");

  // Bit clear clears the chosen bit and keeps the other seven
  chk_bclr_write: assert property (@(posedge mclk_in) disable iff (reset_in)
    s_q3_bclr |=> file_we_out
      && file_wdata_out[$past(bitn)] == 1'b0)
    else $error("bit clear wrote wrong data");
  chk_bclr_keep: assert property (@(posedge mclk_in) disable iff (reset_in)
    s_q3_bclr |=> (file_wdata_out | (8'h01 << $past(bitn)))
      == ($past(file_rdata_in) | (8'h01 << $past(bitn))))
    else $error("bit clear disturbed other bits");

  // Only a bit clear in an executing cycle may write the file
  chk_we_source: assert property (@(posedge mclk_in) disable iff (reset_in)
    file_we_out |-> $past(is_bclr) && $past(cyc_reg) == EXEC)
    else $error("file write from a foreign word");

  // Full file address for both banking modes
  chk_access_bank: assert property (@(posedge mclk_in) disable iff (reset_in)
    (is_bclr && !ir_reg[BANK_OVR_POS]) |=> file_addr_out
      == {($past(ir_reg[7]) ? ACCESS_BANK_HI : ACCESS_BANK_LO), $past(ir_reg[7:0])})
    else $error("access bank address wrong");
  chk_bsr_bank: assert property (@(posedge mclk_in) disable iff (reset_in)
    (is_bclr && ir_reg[BANK_OVR_POS]) |=> file_addr_out
      == {$past(bank_select_reg_in), $past(ir_reg[7:0])})
    else $error("bank select not used");
endmodule

//--- rtl/cbx_phase_gen.sv
// Quarter phase generator: four clocks per instruction cycle.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module cbx_phase_gen (
  input wire logic mclk_in,
  input wire logic reset_in,
  output logic [1:0] phase_out
);
  import cbx_pkg::*;
  // Free-running quarter counter
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      phase_out <= PHASE_RESET;
    end else begin
      phase_out <= phase_out + 2'h1;
    end
  end
endmodule

//--- rtl/cbx_pkg.sv
// Constants for the conditional branch and bit clear execution block.
// Assumes a 21-bit byte program counter and a 12-bit banked data address.
package cbx_pkg;
  localparam int PC_W = 21;
  localparam int DADDR_W = 12;
  localparam logic [7:0] OPC_BR_CARRY_SET = 8'hE2;
  localparam logic [7:0] OPC_BR_CARRY_CLR = 8'hE3;
  localparam logic [7:0] OPC_BR_NEG_SET = 8'hE6;
  localparam logic [7:0] OPC_BR_NEG_CLR = 8'hE7;
  localparam logic [3:0] OPC_BIT_CLEAR = 4'h9;
  localparam int BIT_POS_LSB = 9;
  localparam int BANK_OVR_POS = 8;
  localparam logic [3:0] ACCESS_BANK_LO = 4'h0;
  localparam logic [3:0] ACCESS_BANK_HI = 4'hF;
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [1:0] PHASE_RESET = 2'h0;
  localparam logic [1:0] PHASE_Q4 = 2'h3;
endpackage

//--- rtl/cbx_target_calc.sv
// Relative branch target adder.
// Assumes the PC given is the branch's own address.
`timescale 1ns/1ps
module cbx_target_calc #(
  parameter int PCW = 21
) (
  input wire logic [PCW-1:0] pc_in,
  input wire logic [7:0] disp_in,
  output logic [PCW-1:0] target_out
);
  logic [PCW-1:0] disp_ext;
  // Sign extend and double the word offset
  assign disp_ext = {{(PCW-9){disp_in[7]}}, disp_in, 1'b0};
  // Counter has moved past the branch already
  assign target_out = pc_in + PCW'(2) + disp_ext;
endmodule

//--- tb/cbx_exec_tb.sv
// Self-checking bench for the flag branch and file bit clear block.
// Assumes one word is sampled every four clocks, first at the edge after reset release.
`timescale 1ns/1ps
module cbx_exec_tb;
  import cbx_pkg::*;
  `define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end

  // ****************************************
  // Stimulus and observation signals
  // ****************************************
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [15:0] instr_in = 16'h0000;
  logic [PC_W-1:0] instr_addr_in = '0;
  logic carry_in = 1'b0;
  logic negative_in = 1'b0;
  logic [3:0] bank_select_reg_in = 4'h0;
  logic [7:0] file_rdata_in = 8'h00;
  logic [1:0] phase_out;
  logic pc_load_out, flush_out, file_we_out, busy_out;
  logic [PC_W-1:0] pc_value_out, got_pc;
  logic [DADDR_W-1:0] file_addr_out, got_addr;
  logic [7:0] file_wdata_out, got_data;
  logic [1:0] got_ph;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;
  int n_load, n_flush, n_we, n_busy;

  cbx_exec i_dut (.mclk_in(mclk_in), .reset_in(reset_in), .instr_in(instr_in),
    .instr_addr_in(instr_addr_in), .carry_in(carry_in), .negative_in(negative_in),
    .bank_select_reg_in(bank_select_reg_in), .file_rdata_in(file_rdata_in),
    .phase_out(phase_out), .pc_load_out(pc_load_out), .pc_value_out(pc_value_out),
    .flush_out(flush_out), .file_we_out(file_we_out), .file_addr_out(file_addr_out),
    .file_wdata_out(file_wdata_out), .busy_out(busy_out));

  // 20 MHz clock
  always #25 mclk_in = ~mclk_in;

  // Tally pulses at the falling edge, where registered outputs have settled
  always @(negedge mclk_in) begin
    if (pc_load_out === 1'b1) begin n_load++; got_pc = pc_value_out; end
    if (flush_out === 1'b1) n_flush++;
    if (pc_load_out === 1'b1 || file_we_out === 1'b1) got_ph = phase_out;
    if (busy_out === 1'b1) n_busy++;
    if (file_we_out === 1'b1) begin n_we++; got_addr = file_addr_out; got_data = file_wdata_out; end
  end

  // Hang guard: the whole run needs about 300 cycles
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 1500) begin err_count++; results(); end
  end

  task automatic results();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ****************************************
  // One word in a 12-clock window, idle word after it
  // ****************************************
  // Twelve clocks keep the phase alignment and cover the dead cycle of a taken branch
  task automatic run(input logic [15:0] w, input logic [PC_W-1:0] addr, input logic c,
    input logic n, input logic [3:0] bank_select_reg, input logic [7:0] rd, input logic take,
    input logic [DADDR_W-1:0] e_addr, input logic [7:0] e_data);
    logic [PC_W-1:0] e_pc;
    logic we;
    e_pc = addr + PC_STEP + {{(PC_W-9){w[7]}}, w[7:0], 1'b0};
    we = (w[15:12] == OPC_BIT_CLEAR);
    n_load = 0; n_flush = 0; n_busy = 0; n_we = 0;
    got_ph = 2'h0;
    instr_in <= w; instr_addr_in <= addr; carry_in <= c; negative_in <= n;
    bank_select_reg_in <= bank_select_reg; file_rdata_in <= rd;
    @(posedge mclk_in);
    // Flags flip right after sampling; the outcome must follow the old values
    carry_in <= ~c; negative_in <= ~n;
    repeat (3) @(posedge mclk_in);
    instr_in <= 16'h0000;
    repeat (4) @(posedge mclk_in);
    #30;
    `CHK(n_load, int'(take));
    `CHK(n_flush, int'(take));
    `CHK(n_busy, take ? 4 : 0);
    `CHK(n_we, int'(we));
    if (take) `CHK(got_pc, e_pc)
    // Phase output trails the internal quarter by one clock
    if (take || we) `CHK(got_ph, 2'h2)
    if (we) begin
      `CHK(got_addr, e_addr);
      `CHK(got_data, e_data);
    end
    repeat (4) @(posedge mclk_in);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [7:0] ops [4];
    logic [7:0] disps [8];
    logic f, tk, a;
    logic [2:0] b;
    logic [7:0] fa;
    logic [DADDR_W-1:0] ea;
    ops = '{OPC_BR_CARRY_SET, OPC_BR_CARRY_CLR, OPC_BR_NEG_SET, OPC_BR_NEG_CLR};
    disps = '{8'h80, 8'h7F, 8'h00, 8'hFF, 8'h05, 8'hFB, 8'h40, 8'hC1};
    repeat (4) @(posedge mclk_in);
    reset_in <= 1'b0;
    // Every branch opcode with its flag both ways, extreme offsets included
    for (int k = 0; k < 8; k++) begin
      f = k[0];
      tk = (k / 2 == 0 || k / 2 == 3) ? f : !f;
      run({ops[k / 2], disps[k]}, 21'h001000, f, ~f, 4'h3, 8'hFF, tk, '0, 8'h00);
    end
    for (int k = 0; k < 4; k++) begin
      run({ops[k], disps[7 - k]}, 21'h00ABC0, 1'b1, 1'b1, 4'h3, 8'hFF, k[0] == 1'b0, '0,
        8'h00);
    end
    // Bit clear over every bit, both banking modes, both access halves
    for (int k = 0; k < 8; k++) begin
      b = k[2:0];
      a = k[0];
      fa = k[1] ? 8'h80 : 8'h7F;
      ea = a ? {4'(k + 5), fa} : (fa < ACCESS_SPLIT ? {ACCESS_BANK_LO, fa} : {ACCESS_BANK_HI, fa});
      run({OPC_BIT_CLEAR, b, a, fa}, 21'h000200, 1'b0, 1'b1, 4'(k + 5), 8'hC7 + 8'(k), 1'b0,
        ea, (8'hC7 + 8'(k)) & ~(8'h01 << b));
    end
    // Words outside this block must do nothing
    run(16'hE505, 21'h000300, 1'b1, 1'b1, 4'h1, 8'h00, 1'b0, '0, 8'h00);
    run(16'hFFFF, 21'h000302, 1'b0, 1'b0, 4'h1, 8'h00, 1'b0, '0, 8'h00);
    results();
  end
endmodule
